// ---- cdp_checker.sv ----
/*
 holds: port-level timing checks for the core datapath.
 assumes: bound onto cdp_datapath; one clock, async active-high reset.
*/
module cdp_checker (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// watched inputs
	input wire [2:0] cpu_priority_field,
	input wire [15:0] effective_addr,
	input wire op_abort,
	// watched outputs
	input wire [15:0] core_control_rd,
	input wire [3:0] cpu_level,
	input wire user_irq_block,
	input wire div_busy,
	input wire [22:0] instr_pointer,
	input wire cfg_done,
	input wire [15:0] data_rdata,
	input wire window_sel
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	cc_unused_zero_a: assert property (
		core_control_rd[15:4] == 12'h000 && core_control_rd[1:0] == 2'h0)
		else $error("unused core control bits read nonzero");
	prio_blocks_irq_a: assert property (
		$rose(core_control_rd[3]) |-> ##[0:1] (user_irq_block && cpu_level[3]))
		else $error("priority flag set without blocking");
	level_join_a: assert property (
		$stable(cpu_priority_field) [*3] |-> cpu_level[2:0] == cpu_priority_field)
		else $error("cpu level low bits differ from status field");
	div_length_a: assert property (
		disable iff (rst || op_abort)
		$rose(div_busy) |-> div_busy [*8] ##[10:12] !div_busy)
		else $error("divide length wrong");
	ip_even_a: assert property (
		instr_pointer[0] == 1'b0)
		else $error("instruction pointer odd");
	cfg_load_a: assert property (
		$fell(rst) |-> ##[2:3] cfg_done)
		else $error("config load not done in time");
	data_zero_a: assert property (
		$past(effective_addr) >= 16'h2000 && !$past(effective_addr[15]) |-> data_rdata == 16'h0000)
		else $error("unimplemented data read nonzero");
	view_off_a: assert property (
		!core_control_rd[2] && !$past(core_control_rd[2]) |-> !window_sel)
		else $error("program window selected while view disabled");
endmodule // cdp_checker

bind cdp_datapath cdp_checker chk_u (.clk_sys(clk_sys), .rst(rst),
	.cpu_priority_field(cpu_priority_field), .effective_addr(effective_addr), .op_abort(op_abort),
	.core_control_rd(core_control_rd), .cpu_level(cpu_level), .user_irq_block(user_irq_block),
	.div_busy(div_busy), .instr_pointer(instr_pointer), .cfg_done(cfg_done),
	.data_rdata(data_rdata), .window_sel(window_sel));

// ---- cdp_datapath.v ----
/*
 contents: execution datapath of a 16-bit core: core control register, alu with
 status flags, 17x17 multiplier, iterative divider, barrel shifter, working
 registers, program address stepping, config load, data address decode.
 assumes: instruction decode drives op_* ports one cycle at a time; program and
 data memories answer combinationally on their data inputs.
*/
// What this block does
// - priority bit 3, clearable, blocks user interrupts
// - bit 2 maps program memory into data
// - other core control bits read zero
// - 16-bit two's complement add, sub, shift, logic
// - carry zero sign wrap nibble flags, subtract borrows
// - byte or word, register or memory operands
// - 17x17 multiplier with six operand modes
// - signed/unsigned 32/16 and 16/16 divide
// - quotient to reg 0, remainder reg 1
// - any divisor reg, aligned odd-high dividend pair
// - one iteration per divisor bit, same count
// - single cycle shifts up to 15 bits
// - multi-bit shifts write a register only, never memory
// - arithmetic right, left, logical right shifts
// - 24-bit addresses, 23-bit counter steps two
// - user space below 800000h, table page escape
// - fetch from 000000h after reset
// - primary and alternate vector tables
// - top two program words load configuration
// - 16-bit byte address, top bit program window
// - 8 kbytes implemented, outside reads zero
// - status priority plus bit forms level
// - divide finishes in 19 cycles, interruptible
`include "cdp_defs.vh"

module cdp_datapath (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// instruction controls
	input wire op_valid,
	input wire [3:0] op_code,
	input wire op_byte,
	input wire [3:0] op_src_a,
	input wire [3:0] op_src_b,
	input wire [3:0] op_dst,
	input wire op_a_mem,
	input wire op_b_lit,
	input wire op_dst_mem,
	input wire [15:0] op_literal,
	input wire [2:0] op_mul_mode,
	input wire op_div_signed,
	input wire op_div_long,
	input wire op_abort,
	input wire [15:0] mem_rdata,
	// program flow
	input wire pc_load,
	input wire [22:0] pc_target,
	input wire vec_take,
	input wire vec_alt,
	input wire [6:0] vec_index,
	input wire [7:0] table_page_reg,
	input wire table_op,
	input wire [15:0] tbl_offset,
	// configuration load
	input wire [23:0] cfg_top_addr,
	input wire [23:0] prog_rdata,
	// data address decode
	input wire [15:0] effective_addr,
	input wire [15:0] ram_rdata,
	// status priority field in
	input wire [2:0] cpu_priority_field,
	// outputs
	output reg [15:0] core_control_rd,
	output reg [3:0] cpu_level,
	output reg user_irq_block,
	output reg [15:0] alu_status_word,
	output reg [15:0] mem_wdata,
	output reg mem_we,
	output reg [15:0] quotient_reg,
	output reg [15:0] remainder_reg,
	output reg div_busy,
	output reg [22:0] instr_pointer,
	output reg [23:0] prog_addr,
	output reg prog_fault,
	output reg [47:0] cfg_words,
	output reg cfg_done,
	output reg [15:0] data_rdata,
	output reg window_sel
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [15:0] wreg_r [0:15]; // working register array
	reg priority_high_flag_r; // priority above 7
	reg program_view_enable_r; // program window enable
	reg [4:0] flags_r; // nibble carry, negative, wrap, zero, carry
	reg [4:0] div_cnt_r; // cycles left in divide
	reg [31:0] div_num_r; // shifting dividend/quotient
	reg [16:0] div_rem_r; // partial remainder
	reg [15:0] div_den_r; // divisor magnitude
	reg div_negq_r; // negate quotient at end
	reg div_negr_r; // negate remainder at end
	reg [1:0] cfg_st_r; // configuration loader step
	integer i;

	localparam CFG_W0 = 2'd0;
	localparam CFG_W1 = 2'd1;
	localparam CFG_END = 2'd2;

	// ----------------------------------------
	// operand fetch
	// ----------------------------------------
	reg [15:0] opa; // operand a
	reg [15:0] opb; // operand b
	reg [15:0] res; // result
	reg [4:0] fl_nxt; // next flags
	reg [16:0] sum; // wide sum
	reg [4:0] nib; // low nibble/byte carry
	reg wr_en; // result writes back
	reg [33:0] prod; // signed 17x17 product
	reg [16:0] ma; // extended multiplicand
	reg [16:0] mb; // extended multiplier
	reg [15:0] asr_w; // sign-filling shift result

	// ----------------------------------------
	// alu, shifter and multiplier combinational
	// ----------------------------------------
	always @* begin
		opa = op_a_mem ? mem_rdata : wreg_r[op_src_a];
		opb = op_b_lit ? op_literal : wreg_r[op_src_b];
		if (op_byte) begin
			opa = {8'h00, opa[7:0]};
			opb = {8'h00, opb[7:0]};
		end
		// sign taken from bit 7 in byte mode, kept out of the ternary below
		asr_w = $signed(op_byte ? {{8{opa[7]}}, opa[7:0]} : opa) >>> opb[3:0];
		res = 16'h0000;
		sum = 17'h00000;
		nib = 5'h00;
		fl_nxt = flags_r;
		wr_en = 1'b0;
		prod = 34'h000000000;
		ma = 17'h00000;
		mb = 17'h00000;
		case (op_code)
			`CDP_OP_ADD: begin
				sum = {1'b0, opa} + {1'b0, opb};
				nib = op_byte ? {1'b0, opa[3:0]} + {1'b0, opb[3:0]} : 5'h00;
				res = sum[15:0];
				wr_en = 1'b1;
			end
			`CDP_OP_SUB: begin
				sum = {1'b0, opa} + {1'b0, ~opb} + 17'h00001;
				nib = op_byte ? {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + 5'h01 : 5'h00;
				res = sum[15:0];
				wr_en = 1'b1;
			end
			`CDP_OP_AND: begin
				res = opa & opb;
				wr_en = 1'b1;
			end
			`CDP_OP_IOR: begin
				res = opa | opb;
				wr_en = 1'b1;
			end
			`CDP_OP_XOR: begin
				res = opa ^ opb;
				wr_en = 1'b1;
			end
			// one cycle, up to 15 bits
			`CDP_OP_SHRA: begin
				res = op_byte ? {8'h00, asr_w[7:0]} : asr_w;
				wr_en = 1'b1;
			end
			`CDP_OP_SHL: begin
				res = opa << opb[3:0];
				wr_en = 1'b1;
			end
			`CDP_OP_SHRL: begin
				res = opa >> opb[3:0];
				wr_en = 1'b1;
			end
			`CDP_OP_MUL: begin
				case (op_mul_mode)
					`CDP_MUL_SS: begin
						ma = {opa[15], opa};
						mb = {opb[15], opb};
					end
					`CDP_MUL_SL: begin
						ma = {opa[15], opa};
						mb = {12'h000, op_literal[4:0]};
					end
					`CDP_MUL_UL: begin
						ma = {1'b0, opa};
						mb = {12'h000, op_literal[4:0]};
					end
					`CDP_MUL_US: begin
						ma = {1'b0, opa};
						mb = {opb[15], opb};
					end
					`CDP_MUL_B8: begin
						ma = {9'h000, opa[7:0]};
						mb = {9'h000, opb[7:0]};
					end
					default: begin
						ma = {1'b0, opa};
						mb = {1'b0, opb};
					end
				endcase
				prod = $signed(ma) * $signed(mb);
				res = prod[15:0];
				wr_en = 1'b1;
			end
			default: begin
				res = 16'h0000;
			end
		endcase
		// flag update on arithmetic and logic
		if (wr_en && op_code != `CDP_OP_MUL) begin
			fl_nxt[1] = op_byte ? (res[7:0] == 8'h00) : (res == 16'h0000);
			fl_nxt[3] = op_byte ? res[7] : res[15];
			if (op_code == `CDP_OP_ADD || op_code == `CDP_OP_SUB) begin
				// byte carry: inversion kept at 8 bits inside the concatenation
				fl_nxt[0] = op_byte ? (({1'b0, opa[7:0]} + {1'b0, op_code == `CDP_OP_SUB ?
					~opb[7:0] : opb[7:0]} + {8'h00, op_code == `CDP_OP_SUB}) > 9'h0ff)
					: sum[16];
				fl_nxt[4] = op_byte ? nib[4] : ({1'b0, opa[7:0]} + {1'b0,
					op_code == `CDP_OP_SUB ? ~opb[7:0] : opb[7:0]} +
					{8'h00, op_code == `CDP_OP_SUB}) > 9'h0ff;
				fl_nxt[2] = op_byte ?
					((opa[7] == (opb[7] ^ (op_code == `CDP_OP_SUB))) && (res[7] != opa[7]))
					: ((opa[15] == (opb[15] ^ (op_code == `CDP_OP_SUB))) && (res[15] != opa[15]));
			end
		end
	end

	// ----------------------------------------
	// working registers, flags, divider
	// ----------------------------------------
	reg [16:0] trial; // next partial remainder
	always @* begin
		trial = {div_rem_r[15:0], div_num_r[31]} - {1'b0, div_den_r};
	end

	// divide start operands
	wire [15:0] dvs = wreg_r[op_src_b];
	wire [31:0] dvd = op_div_long ? {wreg_r[{op_src_a[3:1], 1'b1}], wreg_r[{op_src_a[3:1], 1'b0}]}
		: (op_div_signed ? {{16{wreg_r[op_src_a][15]}}, wreg_r[op_src_a]}
		: {16'h0000, wreg_r[op_src_a]});
	wire dvd_neg = op_div_signed & dvd[31];
	wire dvs_neg = op_div_signed & dvs[15];
	wire [31:0] dvd_mag = dvd_neg ? (~dvd + 32'h00000001) : dvd;
	wire [15:0] dvs_mag = dvs_neg ? (~dvs + 16'h0001) : dvs;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 16; i = i + 1) begin
				wreg_r[i] <= 16'h0000;
			end
			priority_high_flag_r <= 1'b0;
			program_view_enable_r <= 1'b0;
			flags_r <= 5'h00;
			div_cnt_r <= 5'h00;
			div_num_r <= 32'h00000000;
			div_rem_r <= 17'h00000;
			div_den_r <= 16'h0000;
			div_negq_r <= 1'b0;
			div_negr_r <= 1'b0;
			mem_wdata <= 16'h0000;
			mem_we <= 1'b0;
		end else begin
			mem_we <= 1'b0;
			if (div_cnt_r != 5'h00) begin
				if (op_abort) begin
					div_cnt_r <= 5'h00;
				end else begin
					div_cnt_r <= div_cnt_r - 5'h01;
					if (div_cnt_r > 5'd3) begin
						if (!trial[16]) begin
							div_rem_r <= trial;
						end else begin
							div_rem_r <= {div_rem_r[15:0], div_num_r[31]};
						end
						div_num_r <= {div_num_r[30:0], ~trial[16]};
					end else if (div_cnt_r == 5'h01) begin
						wreg_r[0] <= div_negq_r ? (~div_num_r[15:0] + 16'h0001) : div_num_r[15:0];
						wreg_r[1] <= div_negr_r ? (~div_rem_r[15:0] + 16'h0001) : div_rem_r[15:0];
					end
				end
			end else if (op_valid) begin
				case (op_code)
					`CDP_OP_DIV: begin
						div_cnt_r <= `CDP_DIV_CYCLES;
						div_den_r <= dvs_mag;
						div_negq_r <= dvd_neg ^ dvs_neg;
						div_negr_r <= dvd_neg;
						div_rem_r <= {1'b0, dvd_mag[31:16]};
						div_num_r <= {dvd_mag[15:0], 16'h0000};
					end
					`CDP_OP_CCW: begin
						program_view_enable_r <= opa[`CDP_CC_VIEW_BIT];
						if (!opa[`CDP_CC_PRIO_BIT]) begin
							priority_high_flag_r <= 1'b0;
						end
					end
					// priority bit set by hardware only
					`CDP_OP_CCC: begin
						priority_high_flag_r <= 1'b1;
					end
					default: begin
						flags_r <= fl_nxt;
						if (op_dst_mem && op_code != `CDP_OP_SHRA && op_code != `CDP_OP_SHL
							&& op_code != `CDP_OP_SHRL) begin
							mem_wdata <= res;
							mem_we <= 1'b1;
						end else if (op_byte) begin
							wreg_r[op_dst] <= {wreg_r[op_dst][15:8], res[7:0]};
						end else begin
							wreg_r[op_dst] <= res;
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// register views
	// ----------------------------------------
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			core_control_rd <= `CDP_CC_RESET;
			cpu_level <= 4'h0;
			user_irq_block <= 1'b0;
			alu_status_word <= 16'h0000;
			quotient_reg <= 16'h0000;
			remainder_reg <= 16'h0000;
			div_busy <= 1'b0;
		end else begin
			core_control_rd <= {12'h000, priority_high_flag_r, program_view_enable_r, 2'b00};
			cpu_level <= {priority_high_flag_r, cpu_priority_field};
			user_irq_block <= priority_high_flag_r | (&cpu_priority_field);
			alu_status_word <= {7'h00, flags_r[4], cpu_priority_field, 1'b0, flags_r[3:0]};
			quotient_reg <= wreg_r[0];
			remainder_reg <= wreg_r[1];
			div_busy <= (div_cnt_r != 5'h00);
		end
	end

	// ----------------------------------------
	// program counter and program address
	// ----------------------------------------
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			instr_pointer <= 23'h000000;
			prog_addr <= `CDP_RESET_VECTOR;
			prog_fault <= 1'b0;
		end else begin
			if (cfg_st_r != CFG_END) begin
				prog_addr <= cfg_top_addr - ((cfg_st_r == CFG_W0) ? 24'h000002 : 24'h000000);
				prog_fault <= 1'b0;
			end else if (vec_take) begin
				instr_pointer <= {14'h0000, vec_alt, vec_index, 1'b0} + 23'h000004;
				prog_addr <= {15'h0000, vec_alt, vec_index, 1'b0} + `CDP_VEC_PRI_LO;
				prog_fault <= 1'b0;
			end else if (table_op) begin
				prog_addr <= {table_page_reg, tbl_offset};
				prog_fault <= 1'b0;
			end else begin
				instr_pointer <= pc_load ? {pc_target[22:1], 1'b0}
					: (div_cnt_r != 5'h00 ? instr_pointer : instr_pointer + `CDP_PC_STEP);
				prog_addr <= {1'b0, instr_pointer};
				prog_fault <= pc_load & (({1'b0, pc_target}) > `CDP_USER_TOP);
			end
		end
	end

	// ----------------------------------------
	// configuration loader
	// ----------------------------------------
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_st_r <= CFG_W0;
			cfg_words <= 48'h000000000000;
			cfg_done <= 1'b0;
		end else begin
			case (cfg_st_r)
				CFG_W0: begin
					cfg_st_r <= CFG_W1;
				end
				CFG_W1: begin
					cfg_words[23:0] <= prog_rdata;
					cfg_st_r <= CFG_END;
				end
				CFG_END: begin
					if (!cfg_done) begin
						cfg_words[47:24] <= prog_rdata;
						cfg_done <= 1'b1;
					end
				end
				default: begin
					cfg_st_r <= CFG_W0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// data effective address decode
	// ----------------------------------------
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			data_rdata <= 16'h0000;
			window_sel <= 1'b0;
		end else begin
			window_sel <= effective_addr[15] & program_view_enable_r;
			if (effective_addr[15]) begin
				data_rdata <= program_view_enable_r ? prog_rdata[15:0] : 16'h0000;
			end else if (effective_addr > `CDP_DATA_TOP) begin
				data_rdata <= 16'h0000;
			end else begin
				data_rdata <= ram_rdata;
			end
		end
	end

endmodule // cdp_datapath

// ---- cdp_defs.vh ----
/*
 contents: constants for the core datapath: core control bit positions, alu operation
 codes, multiplier modes, divider cycle and bit counts, shift kinds, address map figures.
 assumes: included by the datapath module and the test bench; holds definitions only.
*/
`ifndef CDP_DEFS_VH
`define CDP_DEFS_VH

// ----------------------------------------
// core control register
// ----------------------------------------
`define CDP_CC_PRIO_BIT 3
`define CDP_CC_VIEW_BIT 2
`define CDP_CC_RESET 16'h0000

// ----------------------------------------
// alu operation codes
// ----------------------------------------
`define CDP_OP_ADD 4'h0
`define CDP_OP_SUB 4'h1
`define CDP_OP_AND 4'h2
`define CDP_OP_IOR 4'h3
`define CDP_OP_XOR 4'h4
`define CDP_OP_SHRA 4'h5
`define CDP_OP_SHL 4'h6
`define CDP_OP_SHRL 4'h7
`define CDP_OP_MUL 4'h8
`define CDP_OP_DIV 4'h9
`define CDP_OP_CCW 4'ha
`define CDP_OP_CCC 4'hb

// ----------------------------------------
// multiplier modes
// ----------------------------------------
`define CDP_MUL_SS 3'h0
`define CDP_MUL_UU 3'h1
`define CDP_MUL_SL 3'h2
`define CDP_MUL_UL 3'h3
`define CDP_MUL_US 3'h4
`define CDP_MUL_B8 3'h5

// ----------------------------------------
// divider
// ----------------------------------------
`define CDP_DIV_CYCLES 5'd19
`define CDP_DIV_BITS 5'd16

// ----------------------------------------
// address map
// ----------------------------------------
`define CDP_RESET_VECTOR 24'h000000
`define CDP_RESET_TARGET 24'h000002
`define CDP_VEC_PRI_LO 24'h000004
`define CDP_VEC_PRI_HI 24'h0000ff
`define CDP_VEC_ALT_LO 24'h000100
`define CDP_VEC_ALT_HI 24'h0001ff
`define CDP_USER_TOP 24'h7fffff
`define CDP_PC_STEP 23'h000002
`define CDP_DATA_TOP 16'h1fff
`define CDP_TABLE_PAGE_CFG_BIT 7

`endif

// ---- test_cdp_datapath.sv ----
/*
 holds: self-checking bench for the core datapath.
 assumes: cdp_defs.vh on the include path; checker compiled alongside.
*/
`include "cdp_defs.vh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, (got), (exp)); end end

module test_cdp_datapath;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	logic clk_sys = 1'b0, rst = 1'b1;
	logic op_valid = 1'b0, op_byte = 1'b0, op_a_mem = 1'b0, op_b_lit = 1'b0, op_dst_mem = 1'b0;
	logic op_div_signed = 1'b0, op_div_long = 1'b0, op_abort = 1'b0;
	logic pc_load = 1'b0, vec_take = 1'b0, vec_alt = 1'b0, table_op = 1'b0;
	logic [3:0] op_code = 4'h0, op_src_a = 4'h0, op_src_b = 4'h0, op_dst = 4'h0;
	logic [15:0] op_literal = 16'h0000, mem_rdata = 16'h0f0f, tbl_offset = 16'h0000;
	logic [15:0] effective_addr = 16'h0000, ram_rdata = 16'h1234;
	logic [2:0] op_mul_mode = 3'h0, cpu_priority_field = 3'h5;
	logic [22:0] pc_target = 23'h000000;
	logic [6:0] vec_index = 7'h00;
	logic [7:0] table_page_reg = 8'h00;
	logic [23:0] cfg_top_addr = 24'h00abfe;
	wire [23:0] prog_rdata, prog_addr;
	wire [15:0] core_control_rd, alu_status_word, quotient_reg, remainder_reg, data_rdata, mem_wdata;
	wire [3:0] cpu_level;
	wire [22:0] instr_pointer;
	wire [47:0] cfg_words;
	wire user_irq_block, div_busy, cfg_done, window_sel;
	int miscompares = 0, n_checks = 0;
	int cyc[2];
	// literals and expected tables for logic ops and shifts, and register load values
	logic [15:0] lg_lit[3] = '{16'h00ff, 16'h7000, 16'hffff};
	logic [15:0] lg_exp[3] = '{16'h0001, 16'hf001, 16'h7ffe};
	logic [15:0] sh_exp[3] = '{16'hffff, 16'h8000, 16'h0001};
	logic [15:0] ld[4] = '{16'h0064, 16'h0007, 16'hff9c, 16'hffff};

	// program memory answers with a scrambled copy of the address
	assign prog_rdata = prog_addr ^ 24'h5a5a5a;
	// 10 MHz clock
	always #50 clk_sys = ~clk_sys;

	cdp_datapath dut_u (.clk_sys, .rst, .op_valid, .op_code, .op_byte, .op_src_a, .op_src_b,
		.op_dst, .op_a_mem, .op_b_lit, .op_dst_mem, .op_literal, .op_mul_mode, .op_div_signed,
		.op_div_long, .op_abort, .mem_rdata, .pc_load, .pc_target, .vec_take, .vec_alt,
		.vec_index, .table_page_reg, .table_op, .tbl_offset, .cfg_top_addr, .prog_rdata,
		.effective_addr, .ram_rdata, .cpu_priority_field, .core_control_rd, .cpu_level,
		.user_irq_block, .alu_status_word, .mem_wdata, .mem_we(), .quotient_reg,
		.remainder_reg, .div_busy, .instr_pointer, .prog_addr, .prog_fault(), .cfg_words,
		.cfg_done, .data_rdata, .window_sel);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	// advance n edges, then step off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// verdict and stop
	task automatic end_of_test();
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one instruction, then let result and flags land
	task automatic op(input logic [3:0] c, a, b, d, input logic [15:0] lit, input logic bl, am);
		op_code = c;
		op_src_a = a;
		op_src_b = b;
		op_dst = d;
		op_literal = lit;
		op_b_lit = bl;
		op_a_mem = am;
		op_valid = 1'b1;
		tick(1);
		op_valid = 1'b0;
		op_a_mem = 1'b0;
		tick(2);
	endtask

	// data decode probe; open window data itself is not judged
	task automatic dchk(input logic [15:0] ea, d, input logic p);
		effective_addr = ea;
		tick(2);
		if (!ea[15] || !p)
			`CHK(data_rdata, d)
		`CHK(window_sel, p)
	endtask

	// bounded wait for the divider to finish
	task automatic wait_div(output int n);
		n = 0;
		while (div_busy === 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		if (n >= 40) begin
			miscompares++;
			end_of_test();
		end
		tick(2);
	endtask

	// hang guard
	initial begin
		#5000000;
		miscompares++;
		end_of_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		tick(20);
		`CHK(instr_pointer, `CDP_RESET_VECTOR)
		`CHK(core_control_rd, `CDP_CC_RESET)
		rst = 1'b0;
		tick(3);
		`CHK(prog_addr, `CDP_RESET_VECTOR)
		`CHK(cfg_done, 1'b1)
		`CHK(cfg_words === {24'h5af1a4, 24'h5af1a6} || cfg_words === {24'h5af1a6, 24'h5af1a4}, 1'b1)
		dchk(16'h1ffe, 16'h1234, 1'b0);
		dchk(16'h2000, 16'h0000, 1'b0);
		dchk(16'h7ffe, 16'h0000, 1'b0);
		dchk(16'h8000, 16'h0000, 1'b0);
		// signed wrap and nibble carry on word add
		op(`CDP_OP_ADD, 4'hf, 4'h0, 4'h0, 16'h7fff, 1'b1, 1'b0);
		op(`CDP_OP_ADD, 4'h0, 4'h0, 4'h0, 16'h0001, 1'b1, 1'b0);
		`CHK(quotient_reg, 16'h8000)
		`CHK(alu_status_word, 16'h01ac)
		op(`CDP_OP_SUB, 4'h0, 4'h0, 4'h0, 16'h8000, 1'b1, 1'b0);
		`CHK(alu_status_word, 16'h01a3)
		op(`CDP_OP_ADD, 4'h0, 4'h0, 4'h0, 16'h00f1, 1'b1, 1'b1);
		`CHK(quotient_reg, 16'h1000)
		`CHK(alu_status_word, 16'h01a0)
		// logic ops and 15-place shifts
		for (int i = 0; i < 3; i++) begin
			op(`CDP_OP_ADD, 4'hf, 4'h0, 4'h0, 16'h8001, 1'b1, 1'b0);
			op(4'h2 + i[3:0], 4'h0, 4'h0, 4'h0, lg_lit[i], 1'b1, 1'b0);
			`CHK(quotient_reg, lg_exp[i])
			op(`CDP_OP_ADD, 4'hf, 4'h0, 4'h0, 16'h8001, 1'b1, 1'b0);
			op(`CDP_OP_SHRA + i[3:0], 4'h0, 4'h0, 4'h0, 16'h000f, 1'b1, 1'b0);
			`CHK(quotient_reg, sh_exp[i])
		end
		// operands in registers 2 to 5
		for (int i = 0; i < 4; i++)
			op(`CDP_OP_ADD, 4'hf, 4'h0, 4'h2 + i[3:0], ld[i], 1'b1, 1'b0);
		// every multiply mode
		for (int m = 0; m < 6; m++) begin
			op_mul_mode = m[2:0];
			op(`CDP_OP_MUL, 4'h5, 4'h3, 4'h1, 16'h0007, m == 2 || m == 3, 1'b0);
			`CHK(remainder_reg, (m == 5) ? 16'h06f9 : 16'hfff9)
		end
		// short unsigned then long signed divide; an add during it is ignored
		for (int k = 0; k < 2; k++) begin
			op_div_long = k[0];
			op_div_signed = k[0];
			op(`CDP_OP_DIV, k ? 4'h4 : 4'h2, 4'h3, 4'h0, 16'h0000, 1'b0, 1'b0);
			if (k == 0)
				op(`CDP_OP_ADD, 4'hf, 4'h0, 4'h0, 16'h5555, 1'b1, 1'b0);
			wait_div(cyc[k]);
			`CHK(quotient_reg, k ? 16'hfff2 : 16'h000e)
			`CHK(remainder_reg, k ? 16'hfffe : 16'h0002)
		end
		`CHK(cyc[0] + 3, cyc[1])
		`CHK(cyc[1] + 1, `CDP_DIV_CYCLES)
		// a divide cut short frees the unit at once
		op(`CDP_OP_DIV, 4'h2, 4'h3, 4'h0, 16'h0000, 1'b0, 1'b0);
		op_abort = 1'b1;
		tick(1);
		op_abort = 1'b0;
		tick(1);
		`CHK(div_busy, 1'b0)
		// core control write from memory operand 0f0f, priority set, view window
		op(`CDP_OP_CCW, 4'h0, 4'h0, 4'h0, 16'h0000, 1'b0, 1'b1);
		`CHK(core_control_rd, 16'h0004)
		op(`CDP_OP_CCC, 4'h0, 4'h0, 4'h0, 16'h0000, 1'b0, 1'b0);
		`CHK(core_control_rd, 16'h000c)
		`CHK(user_irq_block, 1'b1)
		`CHK(cpu_level, 4'hd)
		dchk(16'h8000, 16'h0000, 1'b1);
		op(`CDP_OP_CCW, 4'hf, 4'h0, 4'h0, 16'h0000, 1'b1, 1'b0);
		`CHK(core_control_rd, 16'h0000)
		`CHK(user_irq_block, 1'b0)
		dchk(16'h8000, 16'h0000, 1'b0);
		// byte ops keep the high byte; register 0 holds fff2 here
		op_byte = 1'b1;
		op(`CDP_OP_ADD, 4'h0, 4'h0, 4'h0, 16'h000e, 1'b1, 1'b0);
		`CHK(quotient_reg, 16'hff00)
		`CHK(alu_status_word, 16'h01a3)
		op(`CDP_OP_SUB, 4'h0, 4'h0, 4'h0, 16'h0001, 1'b1, 1'b0);
		`CHK(quotient_reg, 16'hffff)
		`CHK(alu_status_word, 16'h00a8)
		op_byte = 1'b0;
		// memory result leaves registers alone; shifts ignore the memory target
		op_dst_mem = 1'b1;
		op(`CDP_OP_XOR, 4'h0, 4'h0, 4'h0, 16'h00ff, 1'b1, 1'b0);
		`CHK(mem_wdata, 16'hff00)
		`CHK(quotient_reg, 16'hffff)
		op(`CDP_OP_SHRL, 4'h0, 4'h0, 4'h0, 16'h0004, 1'b1, 1'b0);
		`CHK(quotient_reg, 16'h0fff)
		`CHK(mem_wdata, 16'hff00)
		op_dst_mem = 1'b0;
		// primary and alternate vector entries
		for (int v = 0; v < 2; v++) begin
			vec_alt = v[0];
			vec_index = v ? 7'h03 : 7'h00;
			vec_take = 1'b1;
			tick(1);
			vec_take = 1'b0;
			`CHK(instr_pointer, v ? 23'h00010a : 23'h000004)
			tick(1);
		end
		pc_target = 23'h001234;
		pc_load = 1'b1;
		tick(1);
		pc_load = 1'b0;
		`CHK(instr_pointer, 23'h001234)
		// table access with page bit 7 reaches configuration space
		table_page_reg = 8'h80;
		tbl_offset = 16'h0004;
		table_op = 1'b1;
		tick(1);
		table_op = 1'b0;
		`CHK(prog_addr, 24'h800004)
		// second reset in mid-run with the priority flag set
		op(`CDP_OP_CCC, 4'h0, 4'h0, 4'h0, 16'h0000, 1'b0, 1'b0);
		rst = 1'b1;
		tick(1);
		`CHK(core_control_rd, `CDP_CC_RESET)
		`CHK(cfg_done, 1'b0)
		rst = 1'b0;
		tick(3);
		`CHK(cfg_done, 1'b1)
		`CHK(prog_addr, `CDP_RESET_VECTOR)
		end_of_test();
	end
endmodule // test_cdp_datapath
